// >>> core/sstj_string_jobs.sv
// Operation
// RULE_01: Read parameter string from addressed 7.4 slave
// RULE_02: Return at most 220 bytes, count in byte 2
// RULE_03: Abort with error on reply over 220
// RULE_04: Withhold all received bytes after abort
// RULE_05: Suspend cyclic exchange with busy slave
// RULE_06: Buffer: format bytes, count, string bytes
// RULE_07: Forward parameter string write to slave
// RULE_08: Write byte count taken from byte 2
// RULE_09: Write string bytes pass through unchanged
// RULE_10: Read diagnostic string, count in byte 2
// RULE_11: Controller never supplies count above 220
// RULE_12: Reject write count above 220, nothing sent
`timescale 1ns/1ps
module sstj_string_jobs
  import sstj_pkg::*;
#(
  parameter int MAX_STR = STR_MAX_BYTES,
  parameter int ADDR_W = 5
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Job request from the controller
  input wire logic job_valid_i,
  input wire logic [1:0] job_kind_i,
  input wire logic [ADDR_W-1:0] job_addr_i,
  output logic job_ready_o,
  output logic job_done_o,
  output logic job_err_o,
  // Write job buffer from the controller
  input wire logic host_valid_i,
  input wire logic [7:0] host_data_i,
  input wire logic host_last_i,
  output logic host_ready_o,
  // Read job answer to the controller
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic rsp_last_o,
  input wire logic rsp_ready_i,
  // Slave link
  output logic sl_req_valid_o,
  output logic [1:0] sl_req_kind_o,
  output logic [ADDR_W-1:0] sl_req_addr_o,
  input wire logic sl_req_ready_i,
  output logic sl_tx_valid_o,
  output logic [7:0] sl_tx_data_o,
  output logic sl_tx_last_o,
  input wire logic sl_tx_ready_i,
  input wire logic sl_rx_valid_i,
  input wire logic [7:0] sl_rx_data_i,
  input wire logic sl_rx_last_i,
  output logic sl_abort_o,
  // Cyclic exchange hold
  output logic cyc_hold_o,
  output logic [ADDR_W-1:0] cyc_hold_addr_o
);

  // Position counter is 8 bits wide; buffer must fit below saturation
  if (MAX_STR < 1 || MAX_STR > 250) begin : g_bad_max
    $error("MAX_STR must lie between 1 and 250");
  end
  if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must lie between 1 and 8");
  end

  localparam logic [7:0] MAX_B = 8'(MAX_STR);

  sstj_state_t state_ff, nxt_state;
  logic [7:0] pos_ff, nxt_pos;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [1:0] kind_ff, nxt_kind;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic fail_ff, nxt_fail;
  logic job_ready_ff, job_done_ff, job_err_ff, host_ready_ff;
  logic rsp_valid_ff, rsp_last_ff, sl_req_valid_ff, sl_tx_valid_ff, sl_tx_last_ff;
  logic sl_abort_ff, cyc_hold_ff;
  logic [7:0] rsp_data_ff, sl_tx_data_ff;

  wire job_fire = job_valid_i && job_ready_ff;
  wire host_fire = host_valid_i && host_ready_ff;
  wire req_fire = sl_req_valid_ff && sl_req_ready_i;
  wire tx_fire = sl_tx_valid_ff && sl_tx_ready_i;
  wire rsp_fire = rsp_valid_ff && rsp_ready_i;
  wire rx_take = (state_ff == ST_SL_RX) && sl_rx_valid_i;
  wire rx_over = rx_take && (pos_ff >= MAX_B);
  wire [7:0] pos_step = (pos_ff == POS_SATURATE) ? pos_ff : pos_ff + 8'h01;
  wire [7:0] host_sidx = pos_ff - POS_STR_FIRST;
  wire host_is_str = (pos_ff >= POS_STR_FIRST) && (host_sidx < MAX_B);
  wire host_cnt_big = host_data_i > MAX_B;
  wire [7:0] host_need = cnt_ff + POS_COUNT;
  wire host_short = pos_ff < host_need;

  // Store write: host string bytes or accepted slave bytes
  wire st_we = (host_fire && (state_ff == ST_HOST_RX) && host_is_str) ||
               (rx_take && !rx_over);
  wire [7:0] st_widx = (state_ff == ST_SL_RX) ? pos_ff : host_sidx;
  wire [7:0] st_wdata = (state_ff == ST_SL_RX) ? sl_rx_data_i : host_data_i;

  // Store read follows the next position so data flops line up
  wire [7:0] rsp_sidx = nxt_pos - POS_STR_FIRST;
  wire [7:0] st_ridx = (nxt_state == ST_RSP) ? rsp_sidx : nxt_pos;
  wire [7:0] st_rdata;

  wire [7:0] nxt_rsp_data = (nxt_pos == POS_FMT_HIGH) ? JOB_FORMAT_HIGH :
                            (nxt_pos == POS_FMT_LOW) ? JOB_FORMAT_LOW :
                            (nxt_pos == POS_COUNT) ? nxt_cnt : st_rdata; // [RULE_06] [RULE_02]
  wire [7:0] rsp_end = nxt_cnt + POS_COUNT;
  wire [7:0] tx_end = nxt_cnt - 8'h01;
  wire nxt_busy = (nxt_state == ST_SL_REQ) || (nxt_state == ST_SL_TX) ||
                  (nxt_state == ST_SL_RX);

  sstj_byte_store #(
    .DEPTH(MAX_STR)
  ) u_store (
    .core_clk_i(core_clk_i),
    .we_i(st_we),
    .widx_i(st_widx),
    .wdata_i(st_wdata),
    .ridx_i(st_ridx),
    .rdata_o(st_rdata)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_pos = pos_ff;
    nxt_cnt = cnt_ff;
    nxt_kind = kind_ff;
    nxt_addr = addr_ff;
    nxt_fail = fail_ff;
    case (state_ff)
      ST_IDLE: begin
        if (job_fire) begin
          nxt_kind = job_kind_i;
          nxt_addr = job_addr_i;
          nxt_pos = POS_RESET;
          nxt_cnt = CNT_RESET;
          nxt_fail = 1'b0;
          if (job_kind_i == JOB_WR_PARAM) begin
            nxt_state = ST_HOST_RX; // [RULE_07]
          end else if (job_kind_i == JOB_RD_PARAM || job_kind_i == JOB_RD_DIAG) begin
            nxt_state = ST_SL_REQ; // [RULE_01] [RULE_10]
          end else begin
            nxt_fail = 1'b1;
            nxt_state = ST_FIN;
          end
        end
      end
      ST_HOST_RX: begin
        if (host_fire) begin
          nxt_pos = pos_step;
          if (pos_ff == POS_COUNT) begin
            nxt_cnt = host_data_i; // [RULE_08]
          end
          if (pos_ff == POS_COUNT && host_cnt_big) begin
            // Oversize count: drain the buffer, never reach the slave
            nxt_fail = 1'b1; // [RULE_12] [RULE_11]
            nxt_state = host_last_i ? ST_FIN : ST_DRAIN;
          end else if (host_last_i) begin
            // A buffer shorter than its count is refused as well
            if (pos_ff < POS_COUNT || (pos_ff > POS_COUNT && host_short)) begin
              nxt_fail = 1'b1;
              nxt_state = ST_FIN;
            end else if (pos_ff == POS_COUNT && host_data_i != 8'h00) begin
              nxt_fail = 1'b1;
              nxt_state = ST_FIN;
            end else begin
              nxt_state = ST_SL_REQ;
            end
          end
        end
      end
      ST_DRAIN: begin
        if (host_fire && host_last_i) begin
          nxt_state = ST_FIN;
        end
      end
      ST_SL_REQ: begin
        if (req_fire) begin
          nxt_pos = POS_RESET;
          if (kind_ff != JOB_WR_PARAM) begin
            nxt_state = ST_SL_RX;
          end else if (cnt_ff == CNT_RESET) begin
            nxt_state = ST_FIN;
          end else begin
            nxt_state = ST_SL_TX;
          end
        end
      end
      ST_SL_TX: begin
        if (tx_fire) begin
          nxt_pos = pos_step;
          if (sl_tx_last_ff) begin
            nxt_state = ST_FIN;
          end
        end
      end
      ST_SL_RX: begin
        if (rx_over) begin
          // Nothing gathered so far is handed to the controller
          nxt_fail = 1'b1; // [RULE_03] [RULE_04]
          nxt_state = ST_FIN;
        end else if (rx_take) begin
          nxt_pos = pos_step;
          if (sl_rx_last_i) begin
            nxt_cnt = pos_step; // [RULE_02] [RULE_10]
            nxt_pos = POS_RESET;
            nxt_state = ST_RSP;
          end
        end
      end
      ST_RSP: begin
        if (rsp_fire) begin
          nxt_pos = pos_step;
          if (rsp_last_ff) begin
            nxt_state = ST_FIN;
          end
        end
      end
      ST_FIN: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_ff <= ST_IDLE;
      pos_ff <= POS_RESET;
      cnt_ff <= CNT_RESET;
      kind_ff <= JOB_RD_PARAM;
      addr_ff <= '0;
      fail_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      pos_ff <= nxt_pos;
      cnt_ff <= nxt_cnt;
      kind_ff <= nxt_kind;
      addr_ff <= nxt_addr;
      fail_ff <= nxt_fail;
    end
  end

  // Handshake flags derive from the next state, so each output is a flop
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      job_ready_ff <= 1'b0;
      job_done_ff <= 1'b0;
      job_err_ff <= 1'b0;
      host_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_last_ff <= 1'b0;
      sl_req_valid_ff <= 1'b0;
      sl_tx_valid_ff <= 1'b0;
      sl_tx_last_ff <= 1'b0;
      sl_abort_ff <= 1'b0;
      cyc_hold_ff <= 1'b0;
    end else begin
      job_ready_ff <= nxt_state == ST_IDLE;
      job_done_ff <= nxt_state == ST_FIN;
      job_err_ff <= (nxt_state == ST_FIN) && nxt_fail;
      host_ready_ff <= (nxt_state == ST_HOST_RX) || (nxt_state == ST_DRAIN);
      rsp_valid_ff <= nxt_state == ST_RSP; // [RULE_04]
      rsp_last_ff <= (nxt_state == ST_RSP) && (nxt_pos == rsp_end);
      sl_req_valid_ff <= nxt_state == ST_SL_REQ;
      sl_tx_valid_ff <= nxt_state == ST_SL_TX;
      sl_tx_last_ff <= (nxt_state == ST_SL_TX) && (nxt_pos == tx_end); // [RULE_08]
      sl_abort_ff <= rx_over; // [RULE_03]
      cyc_hold_ff <= nxt_busy; // [RULE_05]
    end
  end

  // Data flops carry no control meaning; no reset needed beyond a defined start
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rsp_data_ff <= 8'h00;
      sl_tx_data_ff <= 8'h00;
    end else begin
      rsp_data_ff <= nxt_rsp_data;
      sl_tx_data_ff <= st_rdata; // [RULE_09]
    end
  end

  assign job_ready_o = job_ready_ff;
  assign job_done_o = job_done_ff;
  assign job_err_o = job_err_ff;
  assign host_ready_o = host_ready_ff;
  assign rsp_valid_o = rsp_valid_ff;
  assign rsp_data_o = rsp_data_ff;
  assign rsp_last_o = rsp_last_ff;
  assign sl_req_valid_o = sl_req_valid_ff;
  assign sl_req_kind_o = kind_ff;
  assign sl_req_addr_o = addr_ff; // [RULE_01]
  assign sl_tx_valid_o = sl_tx_valid_ff;
  assign sl_tx_data_o = sl_tx_data_ff;
  assign sl_tx_last_o = sl_tx_last_ff;
  assign sl_abort_o = sl_abort_ff;
  assign cyc_hold_o = cyc_hold_ff;
  assign cyc_hold_addr_o = addr_ff; // [RULE_05]

endmodule // sstj_string_jobs

// >>> pkg/sstj_pkg.sv
package sstj_pkg;

  // Job buffer layout
  localparam int STR_MAX_BYTES = 220;
  localparam logic [7:0] POS_FMT_HIGH = 8'h00;
  localparam logic [7:0] POS_FMT_LOW = 8'h01;
  localparam logic [7:0] POS_COUNT = 8'h02;
  localparam logic [7:0] POS_STR_FIRST = 8'h03;
  localparam logic [7:0] JOB_FORMAT_HIGH = 8'h00;
  localparam logic [7:0] JOB_FORMAT_LOW = 8'h00;
  localparam logic [7:0] POS_SATURATE = 8'hff;

  // Job kinds on the controller side and on the slave side
  localparam logic [1:0] JOB_RD_PARAM = 2'h0;
  localparam logic [1:0] JOB_WR_PARAM = 2'h1;
  localparam logic [1:0] JOB_RD_DIAG = 2'h2;

  // Reset values
  localparam logic [7:0] POS_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOST_RX,
    ST_DRAIN,
    ST_SL_REQ,
    ST_SL_TX,
    ST_SL_RX,
    ST_RSP,
    ST_FIN
  } sstj_state_t;

endpackage

// >>> core/sstj_byte_store.sv
`timescale 1ns/1ps
module sstj_byte_store #(
  parameter int DEPTH = 220
) (
  input wire logic core_clk_i,
  input wire logic we_i,
  input wire logic [7:0] widx_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] ridx_i,
  output logic [7:0] rdata_o
);

  logic [7:0] rd_mux [DEPTH+1];

  // Index ports are 8 bits wide
  if (DEPTH < 1 || DEPTH > 255) begin : g_bad_depth
    $error("DEPTH must lie between 1 and 255");
  end

  assign rd_mux[0] = 8'h00;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      // One flop per entry keeps a single driver per storage word
      logic [7:0] ent_ff;
      always_ff @(posedge core_clk_i) begin
        if (we_i && (widx_i == 8'(gi))) begin
          ent_ff <= wdata_i;
        end
      end
      // Out of range reads fall through to zero
      assign rd_mux[gi+1] = (ridx_i == 8'(gi)) ? ent_ff : rd_mux[gi];
    end
  endgenerate

  assign rdata_o = rd_mux[DEPTH];

endmodule // sstj_byte_store

// >>> testbench/sstj_properties.sv
`timescale 1ns/1ps
module sstj_properties #(
  parameter int ADDR_W = 5
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic job_done_o,
  input wire logic job_err_o,
  input wire logic rsp_valid_o,
  input wire logic rsp_last_o,
  input wire logic rsp_ready_i,
  input wire logic sl_req_valid_o,
  input wire logic [ADDR_W-1:0] sl_req_addr_o,
  input wire logic sl_req_ready_i,
  input wire logic sl_tx_valid_o,
  input wire logic [7:0] sl_tx_data_o,
  input wire logic sl_tx_ready_i,
  input wire logic sl_abort_o,
  input wire logic cyc_hold_o,
  input wire logic [ADDR_W-1:0] cyc_hold_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  AST_ERR_DONE: assert property (job_err_o |-> job_done_o)
    else $error("err without done");
  AST_ABORT_ERR: assert property (sl_abort_o |-> job_done_o && job_err_o)
    else $error("abort not ended by error");
  AST_ABORT_QUIET: assert property (sl_abort_o |-> !rsp_valid_o [*3])
    else $error("bytes offered after abort");
  AST_HOLD_REQ: assert property (sl_req_valid_o |-> cyc_hold_o)
    else $error("request without hold");
  AST_HOLD_ADDR: assert property (cyc_hold_o && $past(cyc_hold_o) |-> $stable(cyc_hold_addr_o))
    else $error("hold on wrong slave");
  AST_HOLD_TX: assert property (sl_tx_valid_o |-> cyc_hold_o)
    else $error("send without hold");
  AST_TX_KEEP: assert property (sl_tx_valid_o && !sl_tx_ready_i |=> $stable(sl_tx_data_o))
    else $error("send byte changed");
  AST_RSP_END: assert property (rsp_valid_o && rsp_ready_i && rsp_last_o |=> job_done_o)
    else $error("no done after answer");
  cover property (sl_abort_o);
  cover property (rsp_valid_o && rsp_ready_i && rsp_last_o);
  cover property (sl_tx_valid_o && sl_tx_ready_i);
endmodule // sstj_properties
bind sstj_string_jobs sstj_properties #(.ADDR_W(ADDR_W)) u_props (.core_clk_i, .srst_i,
  .job_done_o, .job_err_o, .rsp_valid_o, .rsp_last_o, .rsp_ready_i, .sl_req_valid_o,
  .sl_req_addr_o, .sl_req_ready_i, .sl_tx_valid_o, .sl_tx_data_o, .sl_tx_ready_i,
  .sl_abort_o, .cyc_hold_o, .cyc_hold_addr_o);

// >>> testbench/sstj_slave_model.sv
`timescale 1ns/1ps
module sstj_slave_model (
  input wire logic clk_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_kind_i,
  output logic req_ready_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  input wire logic abort_i,
  input wire logic stall_i,
  input wire logic [8:0] rx_len_i
);
  logic [7:0] tx_mem [256];
  int tx_cnt = 0;
  int tx_last_n = 0;
  int k = 0;
  bit busy = 0;
  initial {req_ready_o, tx_ready_o, rx_valid_o, rx_data_o, rx_last_o} = '0;
  always @(posedge clk_i) begin
    if (req_valid_i && req_ready_o) begin
      busy = (req_kind_i != 2'h1);
      k = 0;
    end
    if (tx_valid_i && tx_ready_o) begin
      tx_mem[tx_cnt[7:0]] = tx_data_i;
      tx_cnt++;
      if (tx_last_i) tx_last_n = tx_cnt;
    end
    if (abort_i) busy = 0;
  end
  // Slow request answer; idle data toggles so a stale byte never looks valid
  always @(negedge clk_i) begin
    req_ready_o <= req_valid_i && !req_ready_o;
    tx_ready_o <= stall_i ? !tx_ready_o : 1'b1;
    rx_valid_o <= busy && k < rx_len_i;
    rx_last_o <= busy && k + 1 == rx_len_i;
    rx_data_o <= busy ? 8'(k) ^ 8'ha5 : ~rx_data_o;
    if (busy) k++;
  end
endmodule // sstj_slave_model

// >>> testbench/sstj_string_jobs_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module sstj_string_jobs_bench;
  import sstj_pkg::*;
  logic core_clk_i = 0, srst_i = 1, job_valid_i = 0, host_valid_i = 0, host_last_i = 0;
  logic rsp_ready_i = 0, stall = 0, rl, e0;
  logic [1:0] job_kind_i = 0, sl_req_kind_o, qk;
  logic [4:0] job_addr_i = 0, sl_req_addr_o, cyc_hold_addr_o, qa;
  logic [7:0] host_data_i = 0, rsp_data_o, sl_tx_data_o, sl_rx_data_i, rb [256];
  logic [8:0] rx_len = 0;
  logic job_ready_o, job_done_o, job_err_o, host_ready_o, rsp_valid_o, rsp_last_o;
  logic sl_req_valid_o, sl_req_ready_i, sl_tx_valid_o, sl_tx_last_o, sl_tx_ready_i;
  logic sl_rx_valid_i, sl_rx_last_i, sl_abort_o, cyc_hold_o;
  int mismatches = 0, checks_done = 0, rn, nab, nhold;
  always #2.5 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) rsp_ready_i <= ~rsp_ready_i;
  always @(posedge core_clk_i) begin
    if (rsp_valid_o && rsp_ready_i) begin
      rb[rn[7:0]] = rsp_data_o;
      rl = rsp_last_o;
      rn++;
    end
    if (sl_req_valid_o && sl_req_ready_i) begin
      qk = sl_req_kind_o;
      qa = sl_req_addr_o;
    end
    if (sl_abort_o) nab++;
    if (cyc_hold_o && cyc_hold_addr_o === job_addr_i) nhold++;
  end
  sstj_string_jobs #(.MAX_STR(220), .ADDR_W(5)) dut (.core_clk_i, .srst_i, .job_valid_i,
    .job_kind_i, .job_addr_i, .job_ready_o, .job_done_o, .job_err_o, .host_valid_i,
    .host_data_i, .host_last_i, .host_ready_o, .rsp_valid_o, .rsp_data_o, .rsp_last_o,
    .rsp_ready_i, .sl_req_valid_o, .sl_req_kind_o, .sl_req_addr_o, .sl_req_ready_i,
    .sl_tx_valid_o, .sl_tx_data_o, .sl_tx_last_o, .sl_tx_ready_i, .sl_rx_valid_i,
    .sl_rx_data_i, .sl_rx_last_i, .sl_abort_o, .cyc_hold_o, .cyc_hold_addr_o);
  sstj_slave_model u_slave (.clk_i(core_clk_i), .req_valid_i(sl_req_valid_o),
    .req_kind_i(sl_req_kind_o), .req_ready_o(sl_req_ready_i), .tx_valid_i(sl_tx_valid_o),
    .tx_data_i(sl_tx_data_o), .tx_last_i(sl_tx_last_o), .tx_ready_o(sl_tx_ready_i),
    .rx_valid_o(sl_rx_valid_i),
    .rx_data_o(sl_rx_data_i), .rx_last_o(sl_rx_last_i), .abort_i(sl_abort_o),
    .stall_i(stall), .rx_len_i(rx_len));
  function automatic logic [7:0] pat(input int k);
    return 8'(k) ^ 8'ha5;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tmo(input int j);
    if (j >= 3000) begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic wait_hi(input bit host);
    int j;
    for (j = 0; j < 3000; j++) begin
      @(posedge core_clk_i);
      if (host ? host_ready_o === 1'b1 : job_ready_o === 1'b1) break;
    end
    tmo(j);
    @(negedge core_clk_i);
  endtask
  task automatic start(input logic [1:0] k);
    rn = 0;
    nab = 0;
    nhold = 0;
    job_kind_i = k;
    job_addr_i = job_addr_i + 5'h3;
    job_valid_i = 1;
    wait_hi(1'b0);
    job_valid_i = 0;
  endtask
  task automatic finish_job(output logic e);
    int j;
    for (j = 0; j < 3000 && job_done_o !== 1'b1; j++) @(negedge core_clk_i);
    tmo(j);
    e = job_err_o;
    // Abort pulses with done; let the monitor see that edge
    @(negedge core_clk_i);
  endtask
  task automatic rd(input logic [1:0] k, input int len);
    logic e;
    int i;
    rx_len = 9'(len);
    start(k);
    finish_job(e);
    `CHK("kind", k, qk)
    `CHK("addr", job_addr_i, qa)
    `CHK("hold", 1'b1, nhold > 0)
    `CHK("err", len > STR_MAX_BYTES, e)
    `CHK("abort", len > STR_MAX_BYTES, nab == 1)
    `CHK("rsp n", len > STR_MAX_BYTES ? 0 : len + 3, rn)
    if (len <= STR_MAX_BYTES) begin
      `CHK("fmt", 16'h0000, {rb[0], rb[1]})
      `CHK("count", 8'(len), rb[2])
      `CHK("last", 1'b1, rl)
      for (i = 0; i < len; i++) `CHK("rsp byte", pat(i), rb[i + 3])
    end
  endtask
  task automatic wr(input int cnt, input int n);
    logic e;
    int i, b;
    b = u_slave.tx_cnt;
    start(JOB_WR_PARAM);
    for (i = 0; i < n + 3; i++) begin
      host_valid_i = 1;
      host_data_i = i == 2 ? 8'(cnt) : i < 2 ? 8'h00 : pat(i - 3);
      host_last_i = i == n + 2;
      wait_hi(1'b1);
    end
    host_valid_i = 0;
    host_last_i = 0;
    finish_job(e);
    `CHK("wr err", cnt > STR_MAX_BYTES, e)
    `CHK("tx n", cnt > STR_MAX_BYTES ? 0 : cnt, u_slave.tx_cnt - b)
    if (cnt > 0 && cnt <= STR_MAX_BYTES) `CHK("tx last", cnt, u_slave.tx_last_n - b)
    `CHK("hold", cnt <= STR_MAX_BYTES, nhold > 0)
    for (i = 0; i < cnt && cnt <= STR_MAX_BYTES; i++)
      `CHK("tx byte", pat(i), u_slave.tx_mem[(b + i) % 256])
  endtask
  initial begin
    repeat (3) @(posedge core_clk_i);
    @(negedge core_clk_i);
    srst_i = 0;
    @(negedge core_clk_i);
    `CHK("ready", 1'b1, job_ready_o)
    rd(JOB_RD_DIAG, 1);
    rd(JOB_RD_PARAM, 220);
    rd(JOB_RD_PARAM, 230);
    rd(JOB_RD_DIAG, 221);
    stall = 1;
    wr(5, 7);
    wr(220, 220);
    wr(221, 221);
    stall = 0;
    wr(3, 3);
    start(2'h3);
    finish_job(e0);
    `CHK("bad kind", 1'b1, e0)
    final_report();
  end
endmodule // sstj_string_jobs_bench
